// ===== shared/ndp_regs.svh
// Register offsets, field positions and timing counts for the command block.
// Assumes a 40 MHz clock and a 32-bit Avalon-MM slave with word addresses.
`ifndef NDP_REGS_SVH
`define NDP_REGS_SVH
// Word offsets (byte address = 4 * index)
`define NDP_OFF_CMD 4'h0
`define NDP_OFF_STATUS 4'h1
`define NDP_OFF_ALTSTAT 4'h2
`define NDP_OFF_DATA 4'h3
`define NDP_OFF_CTRL 4'h4
`define NDP_OFF_ERR 4'h5
`define NDP_OFF_DEVCTL 4'h6
// Status bits
`define NDP_ST_BSY 7
`define NDP_ST_DRQ 3
`define NDP_ST_ERR 0
// Control bits
`define NDP_CT_NIEN 1
// Device-control register bits (cable detect, fault injection)
`define NDP_DC_CBL 0
`define NDP_DC_FAULT 1
// Error register value on abort
`define NDP_ERR_ABRT 8'h04
// Command codes
`define NDP_CMD_NOP 8'h00
`define NDP_CMD_IDENT 8'hec
`define NDP_CMD_IDENT_PKT 8'ha1
`define NDP_CMD_RD_BUF 8'he4
`define NDP_CMD_RD_SECT 8'h20
`define NDP_CMD_RD_MULT 8'hc4
`define NDP_CMD_SEEK 8'h70
`define NDP_CMD_FLUSH 8'he7
`define NDP_CMD_IDLE 8'he3
`define NDP_CMD_SETFEAT 8'hef
// Block geometry
`define NDP_WORDS_PER_BLK 9'd256
`define NDP_MULT_BLOCKS 4'd2
// Identify cable-detect position
`define NDP_ID_CBL_WORD 8'd93
`define NDP_ID_CBL_BIT 13
// Timing
`define NDP_CLK_MHZ 40
`define NDP_BSY_MAX_NS 400
`define NDP_BSY_CYC ((`NDP_BSY_MAX_NS * `NDP_CLK_MHZ) / 1000)
`define NDP_EXEC_CYC 8'd8
`define NDP_PREP_CYC 8'd4
`endif

// ===== shared/ndp_pkg.sv
// Types for the non-data and PIO data-in command block.
// Constants live in ndp_regs.svh.
package ndp_pkg;
   typedef enum logic [2:0] {
      ST_IDLE_QUIET,
      ST_IDLE_IRQ,
      ST_NODATA_EXEC,
      ST_DATAIN_PREP,
      ST_DATAIN_XFER,
      ST_DATAIN_READY_IRQ
   } ndp_state_t;

   typedef enum logic [1:0] {
      CL_NODATA,
      CL_DATAIN,
      CL_INVALID
   } ndp_class_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
      logic readdatavalid;
   } ndp_bus_out_t;

   typedef struct packed {
      ndp_state_t state;
      logic [7:0] cmd;
      logic [7:0] timer;
      logic [8:0] word_idx;
      logic [3:0] blk_left;
      logic irq_pend;
      logic intrq;
      logic nien;
      logic err;
      logic [7:0] err_reg;
      logic cbl_seen;
      logic cbl_live;
      logic fault_inj;
      logic [15:0] data_word;
      logic ack;
      logic [31:0] rdata;
   } ndp_state_all_t;
endpackage : ndp_pkg

// ===== design/ndp_device.sv
// Device side of non-data and PIO data-in command sequencing.
// Assumes an Avalon-MM master with word addressing on one 40 MHz clock.
//
// Contract
// - Non-data command: BSY within 400 ns, pending set
// - Non-data done, nIEN zero: drop BSY, INTRQ
// - Non-data done, nIEN one: drop BSY, no INTRQ
// - Data-in command: BSY within 400 ns, prepare
// - Identify records cable detect in word 93
// - Prepare abort: error, drop BSY, INTRQ if enabled
// - Block ready, nIEN one: transfer, DRQ, no INTRQ
// - Block ready, nIEN zero: DRQ with INTRQ
// - Status read in ready-irq: clear pending, transfer
// - Data read gives next word, block loops
// - Last word read: idle, no pending set
`timescale 1ns/1ps
`include "ndp_regs.svh"
module ndp_device (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic intrq,
   output logic bsy,
   output logic drq
);
   ndp_pkg::ndp_state_all_t s_ff, nxt_s;

   // Class decode of a command byte
   function automatic ndp_pkg::ndp_class_t cmd_class(input logic [7:0] c);
      if (c == `NDP_CMD_IDENT || c == `NDP_CMD_IDENT_PKT ||
          c == `NDP_CMD_RD_BUF || c == `NDP_CMD_RD_SECT ||
          c == `NDP_CMD_RD_MULT)
         cmd_class = ndp_pkg::CL_DATAIN;
      else if (c == `NDP_CMD_NOP || c == `NDP_CMD_SEEK ||
               c == `NDP_CMD_FLUSH || c == `NDP_CMD_IDLE ||
               c == `NDP_CMD_SETFEAT)
         cmd_class = ndp_pkg::CL_NODATA;
      else
         cmd_class = ndp_pkg::CL_INVALID;
   endfunction : cmd_class

   // Data word generator; identify word 93 carries cable detect
   function automatic logic [15:0] word_at(input logic [7:0] c,
         input logic [8:0] i, input logic [3:0] b, input logic cb);
      logic [15:0] w;
      w = {c, i[7:0]} ^ {12'h000, b};
      if ((c == `NDP_CMD_IDENT || c == `NDP_CMD_IDENT_PKT) &&
          i == {1'b0, `NDP_ID_CBL_WORD}) begin
         w = 16'h0000;
         w[`NDP_ID_CBL_BIT] = cb;
      end
      word_at = w;
   endfunction : word_at

   logic busy_st;
   logic drq_st;
   logic st_rd, dat_rd, cmd_wr, ctl_wr, acc;
   logic [7:0] status_byte;

   always_comb begin
      busy_st = (s_ff.state == ndp_pkg::ST_NODATA_EXEC) ||
                (s_ff.state == ndp_pkg::ST_DATAIN_PREP);
      drq_st = (s_ff.state == ndp_pkg::ST_DATAIN_XFER) ||
               (s_ff.state == ndp_pkg::ST_DATAIN_READY_IRQ);
      status_byte = 8'h00;
      status_byte[`NDP_ST_BSY] = busy_st;
      status_byte[`NDP_ST_DRQ] = drq_st;
      status_byte[`NDP_ST_ERR] = s_ff.err;
      // Access acts at the edge it is first seen; waitrequest drops the
      // next cycle, so read data already stands when seen low
      acc = (read || write) && !s_ff.ack;
      st_rd = acc && read && address == `NDP_OFF_STATUS;
      dat_rd = acc && read && address == `NDP_OFF_DATA;
      cmd_wr = acc && write && byteenable[0] && address == `NDP_OFF_CMD;
      ctl_wr = acc && write && byteenable[0] && address == `NDP_OFF_CTRL;
   end

   // Next-state logic for the whole block
   always_comb begin
      nxt_s = s_ff;
      nxt_s.ack = acc;
      if (acc && read) begin
         if (address == `NDP_OFF_STATUS || address == `NDP_OFF_ALTSTAT)
            nxt_s.rdata = {24'h000000, status_byte};
         else if (address == `NDP_OFF_DATA)
            nxt_s.rdata = {16'h0000, drq_st ? s_ff.data_word : 16'h0000};
         else if (address == `NDP_OFF_CTRL)
            nxt_s.rdata = {30'h0, s_ff.nien, 1'b0};
         else if (address == `NDP_OFF_ERR)
            nxt_s.rdata = {24'h000000, s_ff.err_reg};
         else if (address == `NDP_OFF_DEVCTL)
            nxt_s.rdata = {30'h0, s_ff.fault_inj, s_ff.cbl_live};
         else
            nxt_s.rdata = 32'h00000000;
      end
      if (ctl_wr)
         nxt_s.nien = writedata[`NDP_CT_NIEN];
      if (acc && write && byteenable[0] && address == `NDP_OFF_DEVCTL) begin
         nxt_s.cbl_live = writedata[`NDP_DC_CBL];
         nxt_s.fault_inj = writedata[`NDP_DC_FAULT];
      end
      if (s_ff.timer != 8'h00)
         nxt_s.timer = s_ff.timer - 8'h01;
      case (s_ff.state)
         ndp_pkg::ST_IDLE_QUIET, ndp_pkg::ST_IDLE_IRQ: begin
            if (st_rd && s_ff.state == ndp_pkg::ST_IDLE_IRQ) begin
               nxt_s.irq_pend = 1'b0;
               nxt_s.intrq = 1'b0;
               nxt_s.state = ndp_pkg::ST_IDLE_QUIET;
            end
            if (cmd_wr) begin
               // BSY rises the cycle after the write, well under limit
               nxt_s.cmd = writedata[7:0];
               nxt_s.irq_pend = 1'b0;
               nxt_s.intrq = 1'b0;
               nxt_s.err = 1'b0;
               nxt_s.err_reg = 8'h00;
               nxt_s.word_idx = 9'd0;
               if (cmd_class(writedata[7:0]) == ndp_pkg::CL_DATAIN) begin
                  nxt_s.state = ndp_pkg::ST_DATAIN_PREP;
                  nxt_s.timer = `NDP_PREP_CYC;
                  nxt_s.blk_left = (writedata[7:0] == `NDP_CMD_RD_MULT) ?
                     `NDP_MULT_BLOCKS : 4'd1;
               end else begin
                  nxt_s.state = ndp_pkg::ST_NODATA_EXEC;
                  nxt_s.timer = `NDP_EXEC_CYC;
                  nxt_s.blk_left = 4'd0;
               end
            end
         end
         ndp_pkg::ST_NODATA_EXEC: begin
            nxt_s.irq_pend = 1'b1;
            if (s_ff.timer == 8'h00) begin
               if (cmd_class(s_ff.cmd) == ndp_pkg::CL_INVALID ||
                   s_ff.fault_inj) begin
                  nxt_s.err = 1'b1;
                  nxt_s.err_reg = `NDP_ERR_ABRT;
               end
               nxt_s.intrq = !s_ff.nien;
               nxt_s.state = s_ff.nien ? ndp_pkg::ST_IDLE_QUIET :
                  ndp_pkg::ST_IDLE_IRQ;
            end
         end
         ndp_pkg::ST_DATAIN_PREP: begin
            if (s_ff.cmd == `NDP_CMD_IDENT || s_ff.cmd == `NDP_CMD_IDENT_PKT)
               nxt_s.cbl_seen = s_ff.cbl_live;
            if (s_ff.timer == 8'h00) begin
               nxt_s.word_idx = 9'd0;
               nxt_s.data_word = word_at(s_ff.cmd, 9'd0, s_ff.blk_left,
                  s_ff.cbl_seen);
               if (s_ff.fault_inj) begin
                  nxt_s.err = 1'b1;
                  nxt_s.err_reg = `NDP_ERR_ABRT;
                  nxt_s.irq_pend = 1'b1;
                  nxt_s.intrq = !s_ff.nien;
                  nxt_s.state = s_ff.nien ? ndp_pkg::ST_IDLE_QUIET :
                     ndp_pkg::ST_IDLE_IRQ;
               end else if (s_ff.nien) begin
                  nxt_s.state = ndp_pkg::ST_DATAIN_XFER;
               end else begin
                  nxt_s.irq_pend = 1'b1;
                  nxt_s.intrq = 1'b1;
                  nxt_s.state = ndp_pkg::ST_DATAIN_READY_IRQ;
               end
            end
         end
         ndp_pkg::ST_DATAIN_READY_IRQ: begin
            if (st_rd) begin
               nxt_s.irq_pend = 1'b0;
               nxt_s.intrq = 1'b0;
               nxt_s.state = ndp_pkg::ST_DATAIN_XFER;
            end
         end
         ndp_pkg::ST_DATAIN_XFER: begin
            if (dat_rd) begin
               if (s_ff.word_idx == `NDP_WORDS_PER_BLK - 9'd1) begin
                  nxt_s.blk_left = s_ff.blk_left - 4'd1;
                  if (s_ff.blk_left == 4'd1) begin
                     nxt_s.state = ndp_pkg::ST_IDLE_QUIET;
                  end else begin
                     nxt_s.state = ndp_pkg::ST_DATAIN_PREP;
                     nxt_s.timer = `NDP_PREP_CYC;
                  end
               end else begin
                  nxt_s.word_idx = s_ff.word_idx + 9'd1;
                  nxt_s.data_word = word_at(s_ff.cmd, s_ff.word_idx + 9'd1,
                     s_ff.blk_left, s_ff.cbl_seen);
               end
            end
         end
         default: nxt_s.state = ndp_pkg::ST_IDLE_QUIET;
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from flip-flops
   always_comb begin
      readdata = s_ff.rdata;
      waitrequest = !s_ff.ack;
      intrq = s_ff.intrq;
   end

   logic bsy_ff, drq_ff;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bsy_ff <= 1'b0;
         drq_ff <= 1'b0;
      end else begin
         bsy_ff <= (nxt_s.state == ndp_pkg::ST_NODATA_EXEC) ||
                   (nxt_s.state == ndp_pkg::ST_DATAIN_PREP);
         drq_ff <= (nxt_s.state == ndp_pkg::ST_DATAIN_XFER) ||
                   (nxt_s.state == ndp_pkg::ST_DATAIN_READY_IRQ);
      end
   end
   assign bsy = bsy_ff;
   assign drq = drq_ff;

   localparam int BSY_LIM = `NDP_BSY_CYC;

   sequence cmd_write_s;
      write && !s_ff.ack && address == `NDP_OFF_CMD && byteenable[0];
   endsequence

   bsy_rise_a: assert property (@(posedge clock) disable iff (!reset_n)
      (cmd_write_s and (!bsy && !drq)) |-> ##[1:BSY_LIM] bsy)
      else $error("BSY not raised after command");
   nodata_irq_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_NODATA_EXEC && s_ff.timer == 8'h00 &&
      !s_ff.nien |=> intrq && !bsy)
      else $error("Non-data completion lacks INTRQ");
   nodata_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_NODATA_EXEC && s_ff.timer == 8'h00 &&
      s_ff.nien |=> !intrq && !bsy)
      else $error("Non-data completion raised INTRQ");
   xfer_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_DATAIN_XFER |-> drq && !bsy && !intrq)
      else $error("Transfer state levels wrong");
   ready_irq_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_DATAIN_READY_IRQ |-> intrq && drq && !bsy)
      else $error("Ready state lacks INTRQ");
   stat_ack_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_DATAIN_READY_IRQ && st_rd
      |=> !intrq && !s_ff.irq_pend ##1 drq)
      else $error("Status read did not acknowledge");
   last_word_a: assert property (@(posedge clock) disable iff (!reset_n)
      dat_rd && s_ff.word_idx == `NDP_WORDS_PER_BLK - 9'd1 &&
      s_ff.blk_left == 4'd1 |=> !s_ff.irq_pend && !drq && !bsy)
      else $error("Final word left device busy or pending");
   abort_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_DATAIN_PREP && s_ff.timer == 8'h00 &&
      s_ff.fault_inj |=> s_ff.err && !bsy && intrq == !$past(s_ff.nien))
      else $error("Abort path wrong");

   // Execution always leaves the pending flag set
   exec_pend_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_NODATA_EXEC |=> s_ff.irq_pend)
      else $error("Pending flag not set during execution");

   // Data preparation shows busy only
   prep_busy_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_DATAIN_PREP |-> bsy && !drq)
      else $error("Prepare state not busy");

   // Each data read inside a block steps the word index
   word_step_a: assert property (@(posedge clock) disable iff (!reset_n)
      s_ff.state == ndp_pkg::ST_DATAIN_XFER && dat_rd &&
      s_ff.word_idx != `NDP_WORDS_PER_BLK - 9'd1
      |=> s_ff.word_idx == $past(s_ff.word_idx) + 9'd1)
      else $error("Data read did not advance word");

   // Multiple-block read loads its block count
   blk_count_a: assert property (@(posedge clock) disable iff (!reset_n)
      cmd_wr && !bsy && !drq && writedata[7:0] == `NDP_CMD_RD_MULT
      |=> s_ff.blk_left == `NDP_MULT_BLOCKS)
      else $error("Block count not loaded");
endmodule : ndp_device

// ===== dv/ndp_host_model.sv
// Host adapter model: Avalon-MM master tasks and host status steps.
// Assumes read data stands at the edge where waitrequest is seen low.
`timescale 1ns/1ps
`include "ndp_regs.svh"
module ndp_host_model (
   input wire logic clock,
   output logic [3:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic intrq,
   input wire logic bsy,
   input wire logic drq
);
   // Bus idle at time zero
   initial begin
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hf;
   end

   // One access, held until waitrequest is seen low; data taken there
   task automatic xfer(input logic wr, input logic [3:0] a,
                       input logic [7:0] d, output logic [31:0] q);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, d};
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      writedata <= ~{24'h0, d}; // Released data does not hold
      @(posedge clock);
   endtask : xfer

   // Wait for the device interrupt before checking status
   task automatic wait_irq();
      while (intrq !== 1'b1) @(posedge clock);
   endtask : wait_irq

   // Settle delay, then poll status while busy
   task automatic poll(input logic nd, output logic [7:0] st);
      logic [31:0] q;
      repeat (`NDP_BSY_CYC) @(posedge clock);
      do begin
         xfer(1'b0, `NDP_OFF_STATUS, 8'h00, q);
         st = q[7:0];
      end while (st[`NDP_ST_BSY] || (nd && st[`NDP_ST_DRQ]));
   endtask : poll
endmodule : ndp_host_model

// ===== dv/test_nondata_pio_in_command_protocol.sv
// Self-checking bench for the command block, driven by the host model.
// Assumes a 40 MHz clock and the register map of ndp_regs.svh.
`timescale 1ns/1ps
`include "ndp_regs.svh"
module test_nondata_pio_in_command_protocol;
   logic clock, reset_n, read, write, waitrequest, intrq, bsy, drq;
   logic [3:0] address, byteenable;
   logic [31:0] writedata, readdata, q;
   logic [7:0] st;
   logic [7:0] cmds [10];
   logic nien, cbl;
   int n_errors, num_checks, cycles, i;

   ndp_device dut (.clock(clock), .reset_n(reset_n), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .intrq(intrq), .bsy(bsy), .drq(drq));
   ndp_host_model h (.clock(clock), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .intrq(intrq),
      .bsy(bsy), .drq(drq));

   // Clock at 25 ns period
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         $display("BAD timeout expected end seen hang");
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   // Set control, write command, expect busy within the limit
   task automatic issue(input logic [7:0] c, input logic f);
      int k;
      h.xfer(1'b1, `NDP_OFF_CTRL, {6'h0, nien, 1'b0}, q);
      h.xfer(1'b1, `NDP_OFF_DEVCTL, {6'h0, f, cbl}, q);
      h.xfer(1'b1, `NDP_OFF_CMD, c, q);
      for (k = 0; k < `NDP_BSY_CYC && bsy !== 1'b1; k++) @(posedge clock);
      chk("bsy_rise", 16'h1, {15'h0, bsy});
   endtask : issue

   // Full command: nb data blocks (0 for non-data), e error expected
   task automatic run(input logic [7:0] c, input logic f, input logic e,
                      input int nb);
      int b, w;
      logic ok, id;
      id = (c == `NDP_CMD_IDENT) || (c == `NDP_CMD_IDENT_PKT);
      ok = (nb > 0) && !e;
      issue(c, f);
      for (b = 0; b < (nb > 0 ? nb : 1); b++) begin
         if (!nien) begin
            h.wait_irq();
            chk("irq", {13'h0, 2'b10, ok}, {13'h0, intrq, bsy, drq});
         end
         h.poll(nb == 0, st);
         chk("sts", {13'h0, 1'b0, ok, e}, {13'h0, st[7], st[3], st[0]});
         chk("irq_clr", 16'h0, {15'h0, intrq});
         for (w = 0; ok && w < 256; w++) begin
            h.xfer(1'b0, `NDP_OFF_DATA, 8'h00, q);
            if (id && w == 93) begin
               chk("id93", {2'b0, cbl, 13'h0}, q[15:0]);
            end else begin
               chk("word", {c, 8'(w)} ^ 16'(nb - b), q[15:0]);
            end
         end
      end
      if (e) begin
         h.xfer(1'b0, `NDP_OFF_ERR, 8'h00, q);
         chk("err", {8'h0, `NDP_ERR_ABRT}, q[15:0]);
      end
      @(posedge clock);
      chk("end", 16'h0, {13'h0, intrq, bsy, drq});
   endtask : run

   // Main sequence: every command both ways, aborts, unmapped reads
   initial begin
      n_errors = 0;
      num_checks = 0;
      cycles = 0;
      reset_n = 1'b0;
      nien = 1'b0;
      cbl = 1'b0;
      cmds = '{`NDP_CMD_NOP, `NDP_CMD_SEEK, `NDP_CMD_FLUSH, `NDP_CMD_IDLE,
         `NDP_CMD_SETFEAT, `NDP_CMD_IDENT, `NDP_CMD_IDENT_PKT,
         `NDP_CMD_RD_BUF, `NDP_CMD_RD_SECT, `NDP_CMD_RD_MULT};
      void'($urandom(32'hb326));
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      for (i = 0; i < 20; i++) begin
         nien = (i >= 10);
         cbl = 1'($urandom);
         run(cmds[i % 10], 1'b0, 1'b0,
             (i % 10 < 5) ? 0 : ((cmds[i % 10] == `NDP_CMD_RD_MULT) ? 2 : 1));
      end
      for (i = 0; i < 2; i++) begin
         nien = i;
         run(8'h5a, 1'b0, 1'b1, 0);
         run(cmds[5 + $urandom % 5], 1'b1, 1'b1, 1);
      end
      for (i = 0; i < 4; i++) begin
         h.xfer(1'b0, 4'(7 + $urandom % 9), 8'h00, q);
         chk("unmapped", 16'h0, q[15:0]);
      end
      close_out();
   end
endmodule : test_nondata_pio_in_command_protocol
